// ==== rtl/rsf_top.sv ====
// rail switch fault control: boost faults, load switch sequencing and retry, charger selections
`timescale 1ns/10ps
`default_nettype none
`include "rsf_regs.svh"

module rsf_top #(
	// retry wait and delay step in clock cycles; a bench may shrink both
	parameter int RETRY_CYC    = `RSF_RETRY_CYC,
	parameter int DLY_STEP_CYC = `RSF_DLY_STEP_CYC
) (
	input  wire logic                      clk,
	input  wire logic                      nrst,
	input  wire logic [7:0]                avs_address,
	input  wire logic                      avs_read,
	input  wire logic                      avs_write,
	input  wire logic [31:0]               avs_writedata,
	output var  logic [31:0]               avs_readdata,
	output var  logic                      avs_waitrequest,
	input  wire rsf_pkg::rsf_pwr_state_t   pwr_state,
	input  wire rsf_pkg::rsf_boost_sense_t boost_sense,
	input  wire logic [3:0]                sw_limit_hit,
	input  wire rsf_pkg::rsf_chg_status_t  chg_status,
	input  wire logic                      sys_over_input_limit,
	output var  logic                      boost_on,
	output var  logic [3:0]                sw_enable,
	output var  logic [3:0]                sw_discharge,
	output var  rsf_pkg::rsf_chg_ctrl_t    chg_ctrl,
	output var  logic                      host_interrupt_low
);
	import rsf_pkg::*;

	// four channels; 24 counter bits cover the full 14 ms wait at 100 MHz
	localparam int NSW = 4;
	localparam int CW  = 24;

	// pin synchronisers: first stage feeds only the second
	// levels only: a pulse shorter than one clock may be missed
	logic [13:0] sync1_reg;
	logic [13:0] sync2_reg;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1_reg <= 14'h0000;
			sync2_reg <= 14'h0000;
		end else begin
			sync1_reg <= {sys_over_input_limit, chg_status, sw_limit_hit, boost_sense};
			sync2_reg <= sync1_reg;
		end
	end

	// synchronised views; no logic reads these four pin groups raw (pwr_state and the bus are read directly)
	rsf_boost_sense_t bst_s;
	logic [3:0]       lim_s;
	rsf_chg_status_t  chg_s;
	logic             over_s;
	assign bst_s  = sync2_reg[1:0];
	assign lim_s  = sync2_reg[5:2];
	assign chg_s  = sync2_reg[12:6];
	assign over_s = sync2_reg[13];

	// register file state
	// software-visible registers and their next values
	logic [1:0]      bst_ctrl_reg, bst_ctrl_next;
	logic [1:0]      bst_flt_reg, bst_flt_next;
	logic [4:0]      sw_ctrl_reg, sw_ctrl_next;
	logic [31:0]     sw_dly_reg, sw_dly_next;
	logic [7:0]      sw_sleep_reg, sw_sleep_next;
	logic [1:0]      lim_cfg_reg, lim_cfg_next;
	logic [7:0]      event_reg, event_next;
	logic [5:0]      chg_cfg_reg, chg_cfg_next;
	rsf_chg_status_t chg_prev_reg;
	logic [31:0]     rdata_reg, rdata_next;
	logic            wait_reg, wait_next;
	logic            irq_low_reg, irq_low_next;
	rsf_chg_ctrl_t   chg_ctrl_reg, chg_ctrl_next;
	logic [2:0]      lim_irq_pulse;
	logic [NSW-1:0]  sw_en_q;
	logic [NSW-1:0]  sw_dis_q;

	// bus decode
	logic       acc;
	logic       wr_acc;
	logic       rd_acc;
	logic [1:0] flt_set;
	// one access taken per request, answered the next cycle
	// waitrequest high marks the only cycle in which a request is taken
	assign acc    = (avs_read | avs_write) & wait_reg;
	assign wr_acc = acc & avs_write;
	assign rd_acc = acc & avs_read;
	assign flt_set = {bst_s.ov, bst_s.uv};

	// register next values, read data and side effects
	always_comb begin
		bst_ctrl_next = bst_ctrl_reg;
		sw_ctrl_next  = sw_ctrl_reg;
		sw_dly_next   = sw_dly_reg;
		sw_sleep_next = sw_sleep_reg;
		lim_cfg_next  = lim_cfg_reg;
		chg_cfg_next  = chg_cfg_reg;
		rdata_next    = rdata_reg;
		wait_next     = ~acc;
		// writes to read-only or unmapped offsets are dropped
		if (wr_acc) begin
			unique case (avs_address)
				`RSF_OFS_BOOST_CTRL: bst_ctrl_next = avs_writedata[1:0];
				`RSF_OFS_SW_CTRL:    sw_ctrl_next  = avs_writedata[4:0];
				`RSF_OFS_SW_DELAY:   sw_dly_next   = avs_writedata;
				`RSF_OFS_SW_SLEEP:   sw_sleep_next = avs_writedata[7:0];
				`RSF_OFS_LIMIT_CFG:  lim_cfg_next  = avs_writedata[1:0];
				`RSF_OFS_CHG_CFG:    chg_cfg_next  = avs_writedata[5:0];
				default:             ;
			endcase
		end
		// read data held until the next read; unmapped reads give zero
		if (rd_acc) begin
			unique case (avs_address)
				`RSF_OFS_BOOST_CTRL: rdata_next = {30'h0, bst_ctrl_reg};
				`RSF_OFS_BOOST_FLT:  rdata_next = {30'h0, bst_flt_reg};
				`RSF_OFS_SW_CTRL:    rdata_next = {27'h0, sw_ctrl_reg};
				`RSF_OFS_SW_DELAY:   rdata_next = sw_dly_reg;
				`RSF_OFS_SW_SLEEP:   rdata_next = {24'h0, sw_sleep_reg};
				`RSF_OFS_LIMIT_CFG:  rdata_next = {30'h0, lim_cfg_reg};
				`RSF_OFS_SW_STATUS:  rdata_next = {23'h0, chg_ctrl_reg.supplement_mode,
					sw_dis_q, sw_en_q};
				`RSF_OFS_EVENT:      rdata_next = {24'h0, event_reg};
				`RSF_OFS_CHG_CFG:    rdata_next = {26'h0, chg_cfg_reg};
				default:             rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// boost fault flags and interrupt hold
	always_comb begin
		bst_flt_next = bst_flt_reg;
		// masked: live status, nothing latched, no interrupt
		if (!bst_ctrl_reg[`RSF_BST_UNMASK_BIT]) begin
			bst_flt_next = flt_set;
		end else begin
			// read clears only a flag whose condition is gone; a live fault keeps it
			if (rd_acc && avs_address == `RSF_OFS_BOOST_FLT)
				bst_flt_next = bst_flt_reg & flt_set;
			bst_flt_next = bst_flt_next | flt_set;
		end
	end

	// charger change events and switch limit hits, sticky, write one to clear
	// one change bit per group of charger status
	logic [4:0] chg_change;
	always_comb begin
		chg_change[0] = chg_s.temp_zone != chg_prev_reg.temp_zone;
		chg_change[1] = chg_s.bat_low != chg_prev_reg.bat_low;
		chg_change[2] = chg_s.bat_present != chg_prev_reg.bat_present;
		chg_change[3] = chg_s.src_present != chg_prev_reg.src_present;
		chg_change[4] = chg_s.phase != chg_prev_reg.phase;
		event_next = event_reg;
		if (wr_acc && avs_address == `RSF_OFS_EVENT)
			event_next = event_reg & ~avs_writedata[7:0];
		// set wins over a clear in the same cycle
		// so an event that fires during the clear write is never lost
		event_next = event_next | {chg_change, lim_irq_pulse};
	end

	// interrupt pin and charger path outputs
	always_comb begin
		// boost part lapses once the regulator is off or the flags are cleared
		// events keep the pin low until software clears them
		irq_low_next = ~((bst_ctrl_reg[`RSF_BST_ON_BIT] & bst_ctrl_reg[`RSF_BST_UNMASK_BIT]
			& (|bst_flt_reg)) | (|event_reg));
		// supplement overrides the charge enable while the battery feeds the system
		chg_ctrl_next.supplement_mode = over_s;
		chg_ctrl_next.charge_enable   = chg_cfg_reg[`RSF_CHG_EN_BIT] & ~over_s;
		// selections pass straight through; codes ascend with the option lists
		chg_ctrl_next.input_voltage_regulation_mode = chg_cfg_reg[`RSF_CHG_MODE_BIT];
		chg_ctrl_next.input_current_limit_select =
			chg_cfg_reg[`RSF_CHG_CURRENT_LIMIT_EVENT_LSB+:2];
		chg_ctrl_next.input_voltage_threshold_select =
			chg_cfg_reg[`RSF_CHG_VTH_LSB+:2];
	end

	// register file flops; chg_prev keeps the last status so each change counts once
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bst_ctrl_reg <= `RSF_RST_BOOST_CTRL;
			bst_flt_reg  <= 2'h0;
			sw_ctrl_reg  <= `RSF_RST_SW_CTRL;
			sw_dly_reg   <= `RSF_RST_SW_DELAY;
			sw_sleep_reg <= `RSF_RST_SW_SLEEP;
			lim_cfg_reg  <= `RSF_RST_LIMIT_CFG;
			event_reg    <= 8'h00;
			chg_cfg_reg  <= `RSF_RST_CHG_CFG;
			chg_prev_reg <= 7'h00;
			rdata_reg    <= 32'h0000_0000;
			wait_reg     <= 1'b1;
			irq_low_reg  <= 1'b1;
			chg_ctrl_reg <= 7'h00;
		end else begin
			bst_ctrl_reg <= bst_ctrl_next;
			bst_flt_reg  <= bst_flt_next;
			sw_ctrl_reg  <= sw_ctrl_next;
			sw_dly_reg   <= sw_dly_next;
			sw_sleep_reg <= sw_sleep_next;
			lim_cfg_reg  <= lim_cfg_next;
			event_reg    <= event_next;
			chg_cfg_reg  <= chg_cfg_next;
			chg_prev_reg <= chg_s;
			rdata_reg    <= rdata_next;
			wait_reg     <= wait_next;
			irq_low_reg  <= irq_low_next;
			chg_ctrl_reg <= chg_ctrl_next;
		end
	end

	// ports come straight from flops
	assign avs_readdata       = rdata_reg;
	assign avs_waitrequest    = wait_reg;
	assign host_interrupt_low = irq_low_reg;
	assign boost_on           = bst_ctrl_reg[`RSF_BST_ON_BIT];
	assign chg_ctrl           = chg_ctrl_reg;
	assign sw_enable          = sw_en_q;
	assign sw_discharge       = sw_dis_q;

	// channels 0..2 are switches four to six, channel 3 the third regulator as a switch
	logic [NSW-1:0] lim_det_en;
	logic [NSW-1:0] want_on;
	logic [NSW-1:0] lim_enter;
	// regulator channel checks its limit only in load-switch mode
	assign lim_det_en = {lim_cfg_reg[`RSF_LIM_SW4_THIRD_LINEAR_REGULATOR_BIT] & sw_ctrl_reg[`RSF_SW_LDO_LS_BIT],
		{2{lim_cfg_reg[`RSF_LIM_SW56_BIT]}}, lim_cfg_reg[`RSF_LIM_SW4_THIRD_LINEAR_REGULATOR_BIT]};
	// regulator channel retries silently, stand-alone switches report
	assign lim_irq_pulse = lim_enter[2:0];

	// one sequencer per channel, each with its own counter
	genvar g;
	generate
		for (g = 0; g < NSW; g++) begin : g_sw
			rsf_sw_state_t st_reg, st_next;
			logic [CW-1:0] cnt_reg, cnt_next;
			logic          en_reg, en_next;
			logic          dis_reg, dis_next;
			logic [CW-1:0] on_dly, off_dly;

			// delay fields are four-bit step counts
			// a zero field changes state on the next clock
			assign on_dly  = CW'({20'h0, sw_dly_reg[4*g+:4]} * DLY_STEP_CYC);
			assign off_dly = CW'({20'h0, sw_dly_reg[16+4*g+:4]} * DLY_STEP_CYC);

			// target state depends on power state
			// sleep uses bits [3:0], deep sleep bits [7:4]
			always_comb begin
				unique case (pwr_state)
					PWR_SLEEP:      want_on[g] = sw_sleep_reg[g];
					PWR_DEEP_SLEEP: want_on[g] = sw_sleep_reg[4+g];
					default:        want_on[g] = sw_ctrl_reg[g];
				endcase
			end

			// sequencer; one counter per channel times delays, deglitch and retry
			// the counter runs by default; each change of state clears it
			always_comb begin
				st_next      = st_reg;
				cnt_next     = cnt_reg + CW'(1);
				lim_enter[g] = 1'b0;
				unique case (st_reg)
					SW_OFF: begin
						// discharging; waits for an on request
						cnt_next = '0;
						if (want_on[g])
							st_next = SW_ON_DLY;
					end
					SW_ON_DLY: begin
						// a cancelled turn-on goes straight back to off
						if (!want_on[g]) begin
							st_next  = SW_OFF;
							cnt_next = '0;
						end else if (cnt_reg >= on_dly) begin
							st_next  = SW_ON;
							cnt_next = '0;
						end
					end
					SW_ON: begin
						// conducting; the limit counts only with detection on
						cnt_next = '0;
						if (!want_on[g])
							st_next = SW_OFF_DLY;
						else if (lim_s[g] && lim_det_en[g])
							st_next = SW_GLITCH;
					end
					SW_GLITCH: begin
						// a short spike is ignored; only a held limit trips
						if (!want_on[g]) begin
							st_next  = SW_OFF_DLY;
							cnt_next = '0;
						end else if (!lim_s[g] || !lim_det_en[g]) begin
							st_next  = SW_ON;
							cnt_next = '0;
						end else if (cnt_reg >= CW'(`RSF_DEGLITCH_CYC - 1)) begin
							st_next      = SW_RETRY;
							cnt_next     = '0;
							lim_enter[g] = 1'b1;
						end
					end
					SW_RETRY: begin
						// hiccup wait: off and discharging, then a soft start
						if (!want_on[g]) begin
							st_next  = SW_OFF;
							cnt_next = '0;
						end else if (cnt_reg >= CW'(RETRY_CYC - 1)) begin
							st_next  = SW_ON;
							cnt_next = '0;
						end
					end
					SW_OFF_DLY: begin
						// still on through the turn-off delay; an on request cancels it
						if (want_on[g]) begin
							st_next  = SW_ON;
							cnt_next = '0;
						end else if (cnt_reg >= off_dly) begin
							st_next  = SW_OFF;
							cnt_next = '0;
						end
					end
					default: begin
						// unused state codes fall back to off
						st_next  = SW_OFF;
						cnt_next = '0;
					end
				endcase
				// enable registered from the next state; discharge is its exact inverse
				en_next  = (st_next == SW_ON) || (st_next == SW_GLITCH) || (st_next == SW_OFF_DLY);
				dis_next = ~en_next;
			end

			// channel flops; reset leaves every switch off and discharging
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					st_reg  <= SW_OFF;
					cnt_reg <= '0;
					en_reg  <= 1'b0;
					dis_reg <= 1'b1;
				end else begin
					st_reg  <= st_next;
					cnt_reg <= cnt_next;
					en_reg  <= en_next;
					dis_reg <= dis_next;
				end
			end

			assign sw_en_q[g]  = en_reg;
			assign sw_dis_q[g] = dis_reg;
		end
	endgenerate
endmodule
`default_nettype wire

// ==== rtl/rsf_regs.svh ====
// register offsets, field positions, reset values and timing for rail switch fault control
`ifndef RSF_REGS_SVH
`define RSF_REGS_SVH

// avalon word byte offsets
`define RSF_OFS_BOOST_CTRL   8'h00
`define RSF_OFS_BOOST_FLT    8'h04
`define RSF_OFS_SW_CTRL      8'h08
`define RSF_OFS_SW_DELAY     8'h0c
`define RSF_OFS_SW_SLEEP     8'h10
`define RSF_OFS_LIMIT_CFG    8'h14
`define RSF_OFS_SW_STATUS    8'h18
`define RSF_OFS_EVENT        8'h1c
`define RSF_OFS_CHG_CFG      8'h20

// boost control / fault fields
`define RSF_BST_ON_BIT       0
`define RSF_BST_UNMASK_BIT   1
`define RSF_BST_UV_BIT       0
`define RSF_BST_OV_BIT       1

// switch control: [3:0] on bits, [4] third regulator in load-switch mode
`define RSF_SW_LDO_LS_BIT    4
// limit config fields
`define RSF_LIM_SW4_THIRD_LINEAR_REGULATOR_BIT 0
`define RSF_LIM_SW56_BIT     1
// event fields: [2:0] switch limit hits, [7:3] charger changes
`define RSF_EV_LIM_LSB       0
`define RSF_EV_CHG_LSB       3
// charger config fields
`define RSF_CHG_EN_BIT       0
`define RSF_CHG_MODE_BIT     1
`define RSF_CHG_CURRENT_LIMIT_EVENT_LSB     2
`define RSF_CHG_VTH_LSB      4

// reset values
`define RSF_RST_BOOST_CTRL   2'h0
`define RSF_RST_SW_CTRL      5'h00
`define RSF_RST_SW_DELAY     32'h0000_0000
`define RSF_RST_SW_SLEEP     8'h00
`define RSF_RST_LIMIT_CFG    2'h3
`define RSF_RST_CHG_CFG      6'h01

// timing, clock 100 MHz
`define RSF_CLK_MHZ          100
`define RSF_RETRY_MS         14
`define RSF_RETRY_CYC        (`RSF_RETRY_MS * 1000 * `RSF_CLK_MHZ)
`define RSF_DEGLITCH_US      10
`define RSF_DEGLITCH_CYC     (`RSF_DEGLITCH_US * `RSF_CLK_MHZ)
`define RSF_DLY_STEP_MS      1
`define RSF_DLY_STEP_CYC     (`RSF_DLY_STEP_MS * 1000 * `RSF_CLK_MHZ)

`endif

// ==== rtl/rsf_pkg.sv ====
// types shared by rail switch fault control
package rsf_pkg;
	// per-channel load switch sequencer states
	typedef enum logic [2:0] {
		SW_OFF,
		SW_ON_DLY,
		SW_ON,
		SW_GLITCH,
		SW_RETRY,
		SW_OFF_DLY
	} rsf_sw_state_t;

	// power states driven by the sequencer
	typedef enum logic [1:0] {
		PWR_ACTIVE,
		PWR_SLEEP,
		PWR_DEEP_SLEEP
	} rsf_pwr_state_t;

	// boost window comparators
	typedef struct packed {
		logic ov;
		logic uv;
	} rsf_boost_sense_t;

	// charger status levels; any change is an event
	typedef struct packed {
		logic [1:0] temp_zone;
		logic       bat_low;
		logic       bat_present;
		logic       src_present;
		logic [1:0] phase;
	} rsf_chg_status_t;

	// charger selections carried out to the analogue path
	typedef struct packed {
		logic       charge_enable;
		logic       supplement_mode;
		logic       input_voltage_regulation_mode;
		logic [1:0] input_current_limit_select;
		logic [1:0] input_voltage_threshold_select;
	} rsf_chg_ctrl_t;
endpackage

// ==== verif/rsf_top_assertions.sv ====
// port-level checker for rail switch fault control
`timescale 1ns/10ps
`default_nettype none
module rsf_top_assertions
	import rsf_pkg::*;
#(
	parameter int RETRY_CYC = 200
) (
	input wire logic            clk,
	input wire logic            nrst,
	input wire logic            avs_write,
	input wire logic [3:0]      sw_limit_hit,
	input wire rsf_chg_status_t chg_status,
	input wire logic            sys_over_input_limit,
	input wire logic [3:0]      sw_enable,
	input wire logic [3:0]      sw_discharge,
	input wire rsf_chg_ctrl_t   chg_ctrl,
	input wire logic            host_interrupt_low
);
	localparam int RLO = RETRY_CYC - 4;
	localparam int RHI = RETRY_CYC + 8;
	logic [10:0] lim_cnt_reg;
	logic [10:0] lim_cnt_next;

	// cycles that channel 0 has been on while overloaded; saturates, never wraps
	always_comb begin
		lim_cnt_next = 11'h000;
		if (sw_enable[0] && sw_limit_hit[0]) begin
			lim_cnt_next = (lim_cnt_reg == 11'h7ff) ? lim_cnt_reg : lim_cnt_reg + 11'h001;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lim_cnt_reg <= 11'h000;
		end else begin
			lim_cnt_reg <= lim_cnt_next;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_discharge_inverse: assert property (sw_discharge == ~sw_enable)
		else $error("discharge does not mirror a disabled switch");
	a_deglitch_min: assert property ($fell(sw_enable[0]) && sw_limit_hit[0] |-> lim_cnt_reg >= 11'd1000)
		else $error("switch shut down before the deglitch interval");
	a_retry_time: assert property ($fell(sw_enable[0]) && sw_limit_hit[0] |-> ##[RLO:RHI] sw_enable[0])
		else $error("switch not restarted after the retry wait");
	a_limit_irq: assert property ($fell(sw_enable[0]) && sw_limit_hit[0] |-> ##[0:3] !host_interrupt_low)
		else $error("limit shutdown raised no interrupt");
	a_charger_irq: assert property ($changed(chg_status) |-> ##[2:5] !host_interrupt_low)
		else $error("charger change raised no interrupt");
	a_supp_no_charge: assert property (chg_ctrl.supplement_mode |-> !chg_ctrl.charge_enable)
		else $error("charging while in supplement mode");
	a_supp_follows: assert property ($rose(sys_over_input_limit) |-> ##[2:5] chg_ctrl.supplement_mode)
		else $error("supplement mode not entered");
	a_select_by_write: assert property ($changed({chg_ctrl.input_voltage_regulation_mode,
		chg_ctrl.input_current_limit_select, chg_ctrl.input_voltage_threshold_select})
		|-> $past(avs_write) || $past(avs_write, 2))
		else $error("input path selection changed without a write");
endmodule

bind rsf_top rsf_top_assertions #(.RETRY_CYC(RETRY_CYC)) u_chk (
	.clk(clk), .nrst(nrst), .avs_write(avs_write), .sw_limit_hit(sw_limit_hit),
	.chg_status(chg_status), .sys_over_input_limit(sys_over_input_limit),
	.sw_enable(sw_enable), .sw_discharge(sw_discharge), .chg_ctrl(chg_ctrl),
	.host_interrupt_low(host_interrupt_low));
`default_nettype wire

// ==== verif/rsf_plant.sv ====
// analogue side model: switch overload sensing and boost window comparators
`timescale 1ns/10ps
`default_nettype none
module rsf_plant (
	input  wire logic                      clk,
	input  wire logic                      nrst,
	input  wire logic [3:0]                sw_enable,
	input  wire logic [3:0]                overload,
	input  wire logic                      uv,
	input  wire logic                      ov,
	output var  logic [3:0]                sw_limit_hit,
	output var  rsf_pkg::rsf_boost_sense_t boost_sense
);
	logic [3:0] hit_reg;
	logic [3:0] hit_next;

	// an overloaded switch only trips while conducting; one cycle of sense lag
	always_comb hit_next = overload & sw_enable;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hit_reg <= 4'h0;
		end else begin
			hit_reg <= hit_next;
		end
	end
	assign sw_limit_hit = hit_reg;
	assign boost_sense = '{ov: ov, uv: uv};
endmodule
`default_nettype wire

// ==== verif/rsf_top_test.sv ====
// self-checking bench for rail switch fault control
`timescale 1ns/10ps
`default_nettype none
`include "rsf_regs.svh"
module rsf_top_test;
	import rsf_pkg::*;
	logic clk = 0, nrst = 0, avs_read = 0, avs_write = 0, avs_waitrequest, boost_on;
	logic [7:0] avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	rsf_pwr_state_t pwr_state = PWR_ACTIVE;
	rsf_boost_sense_t boost_sense;
	rsf_chg_status_t chg_status = 7'h00;
	rsf_chg_ctrl_t chg_ctrl;
	logic [3:0] sw_limit_hit, sw_enable, sw_discharge, overload = 4'h0;
	logic sys_over_input_limit = 0, host_interrupt_low, uv = 0, ov = 0;
	int miscompares = 0, checks_done = 0, n;
	logic [6:0] chg_bits [5] = '{7'h20, 7'h10, 7'h08, 7'h04, 7'h01};

	always #5 clk = ~clk;

	rsf_top #(.RETRY_CYC(200), .DLY_STEP_CYC(10)) dut (.clk, .nrst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .pwr_state, .boost_sense,
		.sw_limit_hit, .chg_status, .sys_over_input_limit, .boost_on, .sw_enable, .sw_discharge,
		.chg_ctrl, .host_interrupt_low);
	rsf_plant plant (.clk, .nrst, .sw_enable, .overload, .uv, .ov, .sw_limit_hit, .boost_sense);

	// report counts and verdict, then stop
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// one avalon access; request held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (k == 50) begin
			miscompares++;
			$display("FAIL %0t bus wait ran out", $time);
			give_verdict();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
		bus(1'b0, a, 32'h0);
		cmp(q, e, m);
	endtask
	// channel 4 stands for the interrupt line
	function automatic logic sig(input int ch);
		return (ch < 4) ? sw_enable[ch] : host_interrupt_low;
	endfunction
	task automatic wait_for(input int ch, input logic lvl, input int lim);
		n = 0;
		while (sig(ch) !== lvl && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (n == lim) begin
			miscompares++;
			$display("FAIL %0t wait on %0d ran out", $time, ch);
			give_verdict();
		end
	endtask
	task automatic stay(input int ch, input logic lvl, input int cyc, input string m);
		int bad;
		bad = 0;
		repeat (cyc) begin
			@(posedge clk);
			if (sig(ch) !== lvl) bad++;
		end
		cmp(bad, 0, m);
	endtask

	task automatic t_reset;
		cmp(sw_discharge, 4'hf, "discharge at reset");
		rd(`RSF_OFS_LIMIT_CFG, 32'h3, "limit cfg reset");
		rd(`RSF_OFS_CHG_CFG, 32'h1, "charger cfg reset");
		rd(`RSF_OFS_BOOST_CTRL, 32'h0, "boost ctrl reset");
		wr(8'h3c, 32'hffff_ffff);
		rd(8'h3c, 32'h0, "unmapped read");
		$display("reset done");
	endtask
	task automatic t_switch;
		wr(`RSF_OFS_SW_DELAY, 32'h0001_0002);
		wr(`RSF_OFS_SW_CTRL, 32'h1);
		wait_for(0, 1'b1, 60);
		cmp(n >= 15 && n <= 25, 1, "turn-on delay");
		cmp(sw_discharge[0], 1'b0, "discharge while on");
		wr(`RSF_OFS_SW_CTRL, 32'h0);
		stay(0, 1'b1, 6, "turn-off delay");
		wait_for(0, 1'b0, 30);
		cmp(sw_discharge[0], 1'b1, "discharge when off");
		wr(`RSF_OFS_SW_DELAY, 32'h0);
		$display("switch done");
	endtask
	task automatic t_sleep;
		wr(`RSF_OFS_SW_SLEEP, 32'h21);
		pwr_state <= PWR_SLEEP;
		wait_for(0, 1'b1, 20);
		cmp(sw_enable[1], 1'b0, "off in sleep");
		pwr_state <= PWR_DEEP_SLEEP;
		wait_for(1, 1'b1, 20);
		wait_for(0, 1'b0, 20);
		pwr_state <= PWR_ACTIVE;
		wait_for(1, 1'b0, 20);
		$display("sleep done");
	endtask
	task automatic t_limit;
		wr(`RSF_OFS_SW_CTRL, 32'h1);
		wait_for(0, 1'b1, 30);
		overload <= 4'h1;
		wait_for(0, 1'b0, 1100);
		cmp(n >= 1000, 1, "deglitch");
		wait_for(4, 1'b0, 5);
		wait_for(0, 1'b1, 220);
		cmp(n >= 190, 1, "retry wait");
		wait_for(0, 1'b0, 1100);
		overload <= 4'h0;
		wait_for(0, 1'b1, 220);
		rd(`RSF_OFS_EVENT, 32'h1, "limit event");
		wr(`RSF_OFS_EVENT, 32'h1);
		wait_for(4, 1'b1, 5);
		wr(`RSF_OFS_SW_CTRL, 32'h0);
		$display("limit done");
	endtask
	task automatic t_ldo;
		wr(`RSF_OFS_SW_CTRL, 32'h18);
		wait_for(3, 1'b1, 30);
		overload <= 4'h8;
		wait_for(3, 1'b0, 1100);
		stay(4, 1'b1, 30, "no irq in regulator mode");
		rd(`RSF_OFS_EVENT, 32'h0, "no regulator event");
		wr(`RSF_OFS_LIMIT_CFG, 32'h0);
		wr(`RSF_OFS_SW_CTRL, 32'h1a);
		wait_for(3, 1'b1, 250);
		overload <= 4'ha;
		stay(3, 1'b1, 1200, "detect off");
		cmp(sw_enable[1], 1'b1, "pair detect off");
		wr(`RSF_OFS_LIMIT_CFG, 32'h2);
		wait_for(1, 1'b0, 1100);
		cmp(sw_enable[3], 1'b1, "bit one leaves regulator");
		overload <= 4'h0;
		wr(`RSF_OFS_SW_CTRL, 32'h0);
		wr(`RSF_OFS_LIMIT_CFG, 32'h3);
		wr(`RSF_OFS_EVENT, 32'h7);
		wait_for(4, 1'b1, 5);
		$display("regulator done");
	endtask
	task automatic t_boost;
		wr(`RSF_OFS_BOOST_CTRL, 32'h1);
		uv <= 1'b1;
		repeat (5) @(posedge clk);
		rd(`RSF_OFS_BOOST_FLT, 32'h1, "masked live uv");
		cmp(host_interrupt_low, 1'b1, "masked no irq");
		uv <= 1'b0;
		repeat (5) @(posedge clk);
		rd(`RSF_OFS_BOOST_FLT, 32'h0, "masked follows");
		wr(`RSF_OFS_BOOST_CTRL, 32'h3);
		cmp(boost_on, 1'b1, "boost on");
		ov <= 1'b1;
		wait_for(4, 1'b0, 8);
		rd(`RSF_OFS_BOOST_FLT, 32'h2, "ov flag");
		rd(`RSF_OFS_BOOST_FLT, 32'h2, "kept while present");
		ov <= 1'b0;
		stay(4, 1'b0, 6, "irq until read");
		rd(`RSF_OFS_BOOST_FLT, 32'h2, "sticky flag");
		rd(`RSF_OFS_BOOST_FLT, 32'h0, "cleared by read");
		wait_for(4, 1'b1, 5);
		uv <= 1'b1;
		wait_for(4, 1'b0, 8);
		wr(`RSF_OFS_BOOST_CTRL, 32'h2);
		cmp(boost_on, 1'b0, "boost off");
		wait_for(4, 1'b1, 5);
		uv <= 1'b0;
		$display("boost done");
	endtask
	task automatic t_charger;
		for (int k = 0; k < 5; k++) begin
			chg_status <= rsf_chg_status_t'(chg_status ^ chg_bits[k]);
			wait_for(4, 1'b0, 8);
			rd(`RSF_OFS_EVENT, 32'h8 << k, "charger event");
			wr(`RSF_OFS_EVENT, 32'h8 << k);
			wait_for(4, 1'b1, 5);
		end
		for (int c = 0; c < 8; c++) begin
			wr(`RSF_OFS_CHG_CFG, {26'h0, ~c[1:0], c[1:0], c[2], 1'b1});
			repeat (3) @(posedge clk);
			cmp(chg_ctrl, {1'b1, 1'b0, c[2], c[1:0], ~c[1:0]}, "input path codes");
		end
		sys_over_input_limit <= 1'b1;
		repeat (6) @(posedge clk);
		cmp(chg_ctrl.supplement_mode, 1'b1, "supplement");
		cmp(chg_ctrl.charge_enable, 1'b0, "charge stopped");
		rd(`RSF_OFS_SW_STATUS, 32'h1f0, "supplement status");
		sys_over_input_limit <= 1'b0;
		$display("charger done");
	endtask

	// reset for 16 cycles, then run every scenario
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_switch();
		t_sleep();
		t_limit();
		t_ldo();
		t_boost();
		t_charger();
		give_verdict();
	end
endmodule
`default_nettype wire
